// ### include/pcs_pkg.sv
// Package: constants and types for the position cam switch
package pcs_pkg;
  localparam int          PCS_POS_W      = 32;
  localparam int          PCS_REV_INC    = 65536;
  localparam int          PCS_NOUT       = 8;
  localparam int          PCS_NDT        = 4;
  localparam int          PCS_NPOINT     = 16;
  localparam int          PCS_CLK_MHZ    = 100;
  localparam int          PCS_MS_NS      = 1000000;
  localparam int          PCS_CLK_NS     = 10;
  localparam int          PCS_MS_CYC     = PCS_MS_NS / PCS_CLK_NS;
  localparam int          PCS_DT_UNIT_NS = 1000000;
  localparam int          PCS_DT_CYC     = PCS_DT_UNIT_NS / PCS_CLK_NS;
  localparam logic [4:0]  PCS_FILT_OFF   = 5'h00;
  localparam logic        PCS_MODE_SE    = 1'b0;
  localparam logic        PCS_MODE_CR    = 1'b1;

  // Register port offsets
  localparam logic [3:0]  A_TAB          = 4'h0;
  localparam logic [3:0]  A_DATA         = 4'h1;
  localparam logic [3:0]  A_MODE         = 4'h2;
  localparam logic [3:0]  A_HYST         = 4'h3;
  localparam logic [3:0]  A_DT           = 4'h4;
  localparam logic [3:0]  A_FILT         = 4'h5;
  localparam logic [3:0]  A_STAT         = 4'h6;

  typedef struct packed {
    logic signed [PCS_POS_W-1:0] first_point_entry;
    logic signed [PCS_POS_W-1:0] second_point_entry;
  } pcs_pair_t;

  typedef struct packed {
    logic signed [PCS_POS_W-1:0] lo;
    logic signed [PCS_POS_W-1:0] hi;
  } pcs_win_t;
endpackage : pcs_pkg

// ### logic/pcs_window.sv
// Module: one window compare with hysteresis, dead time and filter
`timescale 1ns/1ps
module pcs_window
  import pcs_pkg::*;
#(
  parameter int MS_CYC = PCS_MS_CYC
) (
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  input  wire logic                        ce,
  input  wire logic                        clear,
  input  wire logic                        mode,
  input  wire pcs_pair_t                   pair,
  input  wire logic signed [PCS_POS_W-1:0] pos,
  input  wire logic signed [PCS_POS_W-1:0] vel,
  input  wire logic signed [PCS_POS_W-1:0] hyst,
  input  wire logic signed [15:0]          dead_time,
  input  wire logic [4:0]                  filt_sel,
  output logic                             window_output
);
  pcs_win_t                    win;
  logic signed [PCS_POS_W-1:0] half, look, p;
  logic                        raw, inside_q, filt_q;
  logic [20:0]                 fcnt_q;
  logic [20:0]                 flim;

  always_comb begin
    half = pair.second_point_entry >>> 1;
    // Pair order is set by the travel direction; order the edges
    if (mode == PCS_MODE_CR) begin
      win.lo = pair.first_point_entry - half;
      win.hi = pair.first_point_entry + half;
    end else if (pair.first_point_entry <= pair.second_point_entry) begin
      win.lo = pair.first_point_entry;
      win.hi = pair.second_point_entry;
    end else begin
      win.lo = pair.second_point_entry;
      win.hi = pair.first_point_entry;
    end
  end

  // Dead time shifts the sampled position along the travel: a positive
  // value looks ahead, negative lags, moving points and hysteresis alike
  always_comb begin
    look = PCS_POS_W'(vel * dead_time);
    p    = pos + look;
    if (inside_q)
      raw = (p >= win.lo - hyst) && (p <= win.hi + hyst);
    else
      raw = (p >= win.lo) && (p <= win.hi);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      inside_q <= 1'b0;
    end else if (ce) begin
      inside_q <= clear ? 1'b0 : raw;
    end
  end

  assign flim = 21'(int'(filt_sel) * MS_CYC);

  // Filter: a change must stand for the selected time before it shows
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      filt_q <= 1'b0;
      fcnt_q <= '0;
    end else if (ce) begin
      if (clear) begin
        filt_q <= 1'b0;
        fcnt_q <= '0;
      end else if (filt_sel == PCS_FILT_OFF || inside_q == filt_q) begin
        filt_q <= (filt_sel == PCS_FILT_OFF) ? inside_q : filt_q;
        fcnt_q <= '0;
      end else if (fcnt_q + 21'h000001 >= flim) begin
        filt_q <= inside_q;
        fcnt_q <= '0;
      end else begin
        fcnt_q <= fcnt_q + 21'h000001;
      end
    end
  end

  assign window_output = filt_q;

  filt_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && clear |=> !window_output) else $error("output not cleared");
  filt_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && !clear && filt_sel == PCS_FILT_OFF && $past(ce)
      |=> window_output == $past(inside_q))
    else $error("filter off must pass through");
endmodule : pcs_window

// ### logic/pcs_cam_switch.sv
// Module: dual eight-window electronic cam switch
`timescale 1ns/1ps
// Function
// - Position word counts 65536 increments per motor revolution.
// - Mode 0 uses start/end points, mode 1 centre plus range.
// - Output high while position inside its window, low otherwise.
// - Sixteen entries per instance; entries 2n-1, 2n serve output n.
// - On/off role of each pair point follows travel direction.
// - Centre mode: first entry centre, second the window width.
// - Second instance only: one hysteresis for all eight outputs.
// - Second instance only: dead time for outputs one to four.
// - Dead time shifts switching points and hysteresis thresholds.
// - Positive dead time switches earlier by the set time.
// - Negative dead time switches later by the set time.
// - Filter select: 0 off, or 1, 2, 4, 8, 16 milliseconds.
// - Filter in second instance only, on its first four outputs.
// - Position input normally fed from the actual position value.
module pcs_cam_switch
  import pcs_pkg::*;
#(
  parameter int MS_CYC = PCS_MS_CYC
) (
  input  wire logic                           mclk,
  input  wire logic                           rst_n,
  input  wire logic                           ce,
  input  wire logic [PCS_POS_W-1:0]           cam_a_position_input,
  input  wire logic [PCS_POS_W-1:0]           cam_b_position_input,
  input  wire logic                           cam_a_clear,
  input  wire logic                           cam_b_clear,
  input  wire logic [3:0]                     reg_addr,
  input  wire logic [31:0]                    reg_wdata,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  output logic      [31:0]                    reg_rdata,
  output logic      [PCS_NOUT-1:0]            cam_a_window_output,
  output logic      [PCS_NOUT-1:0]            cam_b_window_output
);
  ////////////////////////////////////////////////////////////////////////
  // Reset release and input sync
  logic rs1_q, rs2_q, rst_s_n;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rs1_q <= 1'b0;
      rs2_q <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rs2_q <= rs1_q;
    end
  end
  assign rst_s_n = rs2_q;

  // Positions and clears come from outside this clock: two stages each
  logic [PCS_POS_W-1:0] pa1_q, pa2_q, pb1_q, pb2_q;
  logic [1:0]           cl1_q, cl2_q;
  always_ff @(posedge mclk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      pa1_q <= '0;
      pa2_q <= '0;
      pb1_q <= '0;
      pb2_q <= '0;
      cl1_q <= 2'h3;
      cl2_q <= 2'h3;
    end else if (ce) begin
      pa1_q <= cam_a_position_input;
      pa2_q <= pa1_q;
      pb1_q <= cam_b_position_input;
      pb2_q <= pb1_q;
      cl1_q <= {cam_b_clear, cam_a_clear};
      cl2_q <= cl1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Travel speed per millisecond, for the dead time look-ahead
  logic signed [PCS_POS_W-1:0] pa_prev_q, pb_prev_q, va_q, vb_q;
  logic [20:0]                 vdiv_q;
  always_ff @(posedge mclk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      pa_prev_q <= '0;
      pb_prev_q <= '0;
      va_q      <= '0;
      vb_q      <= '0;
      vdiv_q    <= '0;
    end else if (ce) begin
      // Speed sampled once per millisecond so a coarse encoder still
      // yields a usable figure; a trade of latency for resolution
      if (32'(vdiv_q) + 32'h1 >= 32'(MS_CYC)) begin
        vdiv_q    <= '0;
        // Survives the 32-bit position word wrapping, thanks to 2's complement
        va_q      <= $signed(pa2_q) - pa_prev_q;
        vb_q      <= $signed(pb2_q) - pb_prev_q;
        pa_prev_q <= $signed(pa2_q);
        pb_prev_q <= $signed(pb2_q);
      end else begin
        vdiv_q <= vdiv_q + 21'h000001;
      end
      // A cleared instance restarts its look-ahead from standstill
      if (cl2_q[0]) va_q <= '0;
      if (cl2_q[1]) vb_q <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers
  pcs_pair_t           tab_a_q [PCS_NOUT];
  pcs_pair_t           tab_b_q [PCS_NOUT];
  logic [4:0]          tsel_q;
  logic [1:0]          mode_q;
  logic signed [31:0]  hyst_q;
  logic signed [15:0]  dt_q [PCS_NDT];
  logic [4:0]          filt_q;

  function automatic logic filt_legal(input logic [4:0] v);
    return v inside {5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10};
  endfunction : filt_legal

  always_ff @(posedge mclk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      tsel_q <= '0;
      mode_q <= '0;
      hyst_q <= '0;
      filt_q <= '0;
      for (int i = 0; i < PCS_NOUT; i++) begin
        tab_a_q[i] <= '0;
        tab_b_q[i] <= '0;
      end
      for (int i = 0; i < PCS_NDT; i++) dt_q[i] <= '0;
    end else if (ce && reg_wr) begin
      unique case (reg_addr)
        A_TAB:  tsel_q <= reg_wdata[4:0];
        A_DATA: begin
          // Index bit 4 picks instance, bits 3:1 output, bit 0 entry
          if (!tsel_q[4]) begin
            if (!tsel_q[0]) tab_a_q[tsel_q[3:1]].first_point_entry
                              <= reg_wdata;
            else            tab_a_q[tsel_q[3:1]].second_point_entry
                              <= reg_wdata;
          end else begin
            if (!tsel_q[0]) tab_b_q[tsel_q[3:1]].first_point_entry
                              <= reg_wdata;
            else            tab_b_q[tsel_q[3:1]].second_point_entry
                              <= reg_wdata;
          end
        end
        A_MODE: mode_q <= reg_wdata[1:0];
        A_HYST: hyst_q <= reg_wdata[31] ? 32'h0 : reg_wdata;
        A_DT: dt_q[reg_wdata[17:16]] <= reg_wdata[15:0];
        // Illegal filter codes are ignored, keeping the last legal one
        A_FILT: if (filt_legal(reg_wdata[4:0])) filt_q <= reg_wdata[4:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read back
  logic [PCS_POS_W-1:0] rd_pt;
  always_comb begin
    rd_pt = '0;
    if (!tsel_q[4])
      rd_pt = tsel_q[0] ? tab_a_q[tsel_q[3:1]].second_point_entry
                        : tab_a_q[tsel_q[3:1]].first_point_entry;
    else
      rd_pt = tsel_q[0] ? tab_b_q[tsel_q[3:1]].second_point_entry
                        : tab_b_q[tsel_q[3:1]].first_point_entry;
  end

  always_ff @(posedge mclk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      reg_rdata <= '0;
    end else if (ce) begin
      reg_rdata <= '0;
      if (reg_rd) begin
        unique case (reg_addr)
          A_TAB:  reg_rdata <= {27'h0, tsel_q};
          A_DATA: reg_rdata <= rd_pt;
          A_MODE: reg_rdata <= {30'h0, mode_q};
          A_HYST: reg_rdata <= hyst_q;
          A_DT:   reg_rdata <= {{16{dt_q[0][15]}}, dt_q[0]};
          A_FILT: reg_rdata <= {27'h0, filt_q};
          A_STAT: reg_rdata <= {16'h0, cam_b_window_output,
                                cam_a_window_output};
          default: reg_rdata <= '0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Windows: first instance plain, second with extras
  genvar g;
  generate
    for (g = 0; g < PCS_NOUT; g++) begin : g_win
      pcs_window #(.MS_CYC(MS_CYC)) u_a (
        .mclk          (mclk),
        .rst_n         (rst_s_n),
        .ce            (ce),
        .clear         (cl2_q[0]),
        .mode          (mode_q[0]),
        .pair          (tab_a_q[g]),
        .pos           ($signed(pa2_q)),
        .vel           (va_q),
        .hyst          (32'sh0),
        .dead_time     (16'sh0),
        .filt_sel      (PCS_FILT_OFF),
        .window_output (cam_a_window_output[g])
      );
      pcs_window #(.MS_CYC(MS_CYC)) u_b (
        .mclk          (mclk),
        .rst_n         (rst_s_n),
        .ce            (ce),
        .clear         (cl2_q[1]),
        .mode          (mode_q[1]),
        .pair          (tab_b_q[g]),
        .pos           ($signed(pb2_q)),
        .vel           (vb_q),
        .hyst          (hyst_q),
        .dead_time     (g < PCS_NDT ? dt_q[g % PCS_NDT] : 16'sh0),
        .filt_sel      (g < PCS_NDT ? filt_q : PCS_FILT_OFF),
        .window_output (cam_b_window_output[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_clear_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
    ce && cl2_q[0] |=> cam_a_window_output == '0)
    else $error("instance a not cleared");
  b_clear_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
    ce && cl2_q[1] |=> cam_b_window_output == '0)
    else $error("instance b not cleared");
  filt_legal_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
    filt_legal(filt_q)) else $error("illegal filter code held");
  hyst_pos_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
    hyst_q >= 0) else $error("negative hysteresis");
  rd_zero_a: assert property (@(posedge mclk) disable iff (!rst_s_n)
    ce && !reg_rd |=> reg_rdata == '0) else $error("stray read data");
  a_on_c: cover property (@(posedge mclk) disable iff (!rst_s_n)
    $rose(cam_a_window_output[0]));
  b_on_c: cover property (@(posedge mclk) disable iff (!rst_s_n)
    $rose(cam_b_window_output[0]));
  cr_c: cover property (@(posedge mclk) disable iff (!rst_s_n)
    mode_q[1] && cam_b_window_output[7]);
endmodule : pcs_cam_switch

// ### testbench/pcs_pos_model.sv
// Position source model standing in for the drive's actual-position logic
`timescale 1ns/1ps
module pcs_pos_model
  import pcs_pkg::*;
(
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  input  wire logic signed [PCS_POS_W-1:0] target,
  input  wire logic signed [PCS_POS_W-1:0] step,
  output logic signed [PCS_POS_W-1:0]      position,
  output logic                             arrived
);
  // Ramps toward the target so travel direction is well defined at edges
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      position <= 32'sh0;
    end else if (target - position > step) begin
      position <= position + step;
    end else if (position - target > step) begin
      position <= position - step;
    end else begin
      position <= target;
    end
  end

  assign arrived = (position == target);
endmodule : pcs_pos_model

// ### testbench/pcs_cam_switch_tb.sv
// Self-checking bench for the dual cam switch
`timescale 1ns/1ps
module pcs_cam_switch_tb
  import pcs_pkg::*;
;
  logic                        mclk = 1'b0;
  logic                        rst_n = 1'b0;
  logic                        ce_in = 1'b1;
  logic                        clr_a = 1'b0;
  logic                        clr_b = 1'b0;
  logic [3:0]                  reg_addr = 4'h0;
  logic [31:0]                 reg_wdata = 32'h0;
  logic                        reg_wr = 1'b0;
  logic                        reg_rd = 1'b0;
  logic [31:0]                 reg_rdata;
  logic [7:0]                  out_a;
  logic [7:0]                  out_b;
  logic signed [PCS_POS_W-1:0] tgt_a = 32'sh0;
  logic signed [PCS_POS_W-1:0] tgt_b = 32'sh0;
  logic signed [PCS_POS_W-1:0] stp = 32'sh7;
  logic signed [PCS_POS_W-1:0] pos_a;
  logic signed [PCS_POS_W-1:0] pos_b;
  logic                        arr_a;
  logic                        arr_b;
  int                          fail_count = 0;
  int                          checks_done = 0;
  int                          cycles = 0;

  always #5 mclk = ~mclk;

  pcs_pos_model mdl_a (.mclk(mclk), .rst_n(rst_n), .target(tgt_a),
    .step(stp), .position(pos_a), .arrived(arr_a));
  pcs_pos_model mdl_b (.mclk(mclk), .rst_n(rst_n), .target(tgt_b),
    .step(stp), .position(pos_b), .arrived(arr_b));

  pcs_cam_switch #(.MS_CYC(10)) uut (
    .mclk(mclk), .rst_n(rst_n), .ce(ce_in),
    .cam_a_position_input(pos_a), .cam_b_position_input(pos_b),
    .cam_a_clear(clr_a), .cam_b_clear(clr_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cam_a_window_output(out_a), .cam_b_window_output(out_b));

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    if (fail_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  // Hang guard: the whole sequence needs a few thousand cycles at most
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1 chk(reg_rdata, exp);
    @(posedge mclk);
  endtask : rd

  // Index layout: bit4 instance, bits3:1 output minus one, bit0 entry
  task automatic pt(input logic b, input int o, input logic e, input int v);
    wr(4'h0, {27'h0, b, 3'(o - 1), e});
    wr(4'h1, 32'(v));
  endtask : pt

  // Moves both positions, then allows the four-cycle reaction to land
  task automatic go(input int a, input int b);
    int n;
    tgt_a <= 32'(a);
    tgt_b <= 32'(b);
    @(posedge mclk);
    for (n = 0; n < 2000 && !(arr_a && arr_b); n++) @(posedge mclk);
    repeat (6) @(posedge mclk);
  endtask : go

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    int k;
    logic [4:0] codes [6] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h00};
    rd(4'h2, 32'h0);
    pt(1'b0, 2, 1'b0, 100);
    rd(4'h1, 32'h64);
    pt(1'b0, 2, 1'b0, 0);
    rd(4'hF, 32'h0);
    for (k = 0; k < 6; k++) begin
      wr(4'h5, {27'h0, codes[k]});
      rd(4'h5, {27'h0, codes[k]});
    end
    wr(4'h5, 32'h3);
    rd(4'h5, 32'h0);
  endtask : t_regs

  task automatic t_start_end;
    pt(1'b0, 1, 1'b0, 100);
    pt(1'b0, 1, 1'b1, 200);
    pt(1'b0, 8, 1'b0, 200);
    pt(1'b0, 8, 1'b1, 100);
    go(150, 0);
    chk({24'h0, out_a}, 32'h81);
    go(250, 0);
    chk({24'h0, out_a}, 32'h00);
    go(200, 0);
    chk({24'h0, out_a}, 32'h81);
    go(99, 0);
    chk({24'h0, out_a}, 32'h00);
    go(100, 0);
    chk({24'h0, out_a}, 32'h81);
  endtask : t_start_end

  task automatic t_centre;
    wr(4'h2, 32'h3);
    rd(4'h2, 32'h3);
    go(180, 0);
    chk({24'h0, out_a}, 32'h81);
    chk({24'h0, out_b}, 32'hFF);
    go(230, 0);
    chk({24'h0, out_a}, 32'h80);
    go(20, 0);
    chk({24'h0, out_a}, 32'h01);
    wr(4'h2, 32'h0);
    go(20, 0);
    chk({24'h0, out_a}, 32'h00);
  endtask : t_centre

  task automatic t_hyst;
    pt(1'b1, 1, 1'b0, 100);
    pt(1'b1, 1, 1'b1, 200);
    pt(1'b1, 8, 1'b0, 100);
    pt(1'b1, 8, 1'b1, 200);
    wr(4'h3, 32'h32);
    go(150, 150);
    chk({24'h0, out_b}, 32'h81);
    go(230, 230);
    chk({24'h0, out_b}, 32'h81);
    chk({24'h0, out_a}, 32'h00);
    go(260, 260);
    chk({24'h0, out_b}, 32'h00);
    go(230, 230);
    chk({24'h0, out_b}, 32'h00);
    go(190, 190);
    chk({24'h0, out_b}, 32'h81);
    rd(4'h6, 32'h8181);
  endtask : t_hyst

  task automatic t_clear;
    clr_b <= 1'b1;
    repeat (6) @(posedge mclk);
    chk({24'h0, out_b}, 32'h00);
    chk({24'h0, out_a}, 32'h81);
    clr_b <= 1'b0;
    clr_a <= 1'b1;
    repeat (8) @(posedge mclk);
    chk({24'h0, out_b}, 32'h81);
    chk({24'h0, out_a}, 32'h00);
    clr_a <= 1'b0;
  endtask : t_clear

  // Steady travel of 70 increments per ms; outputs lag the model by 28
  task automatic t_dead;
    wr(4'h3, 32'h0);
    pt(1'b1, 5, 1'b0, 100);
    pt(1'b1, 5, 1'b1, 200);
    wr(4'h4, 32'h00000002);
    go(0, -300);
    tgt_b <= 32'sh3E8;
    while (pos_b < 40) @(posedge mclk);
    chk({31'h0, out_b[0]}, 32'h1);
    chk({31'h0, out_b[4]}, 32'h0);
    while (pos_b < 150) @(posedge mclk);
    chk({31'h0, out_b[0]}, 32'h0);
    chk({31'h0, out_b[4]}, 32'h1);
    wr(4'h4, 32'h0000FFFE);
    rd(4'h4, 32'hFFFFFFFE);
    go(0, -300);
    tgt_b <= 32'sh3E8;
    while (pos_b < 150) @(posedge mclk);
    chk({31'h0, out_b[0]}, 32'h0);
    while (pos_b < 280) @(posedge mclk);
    chk({31'h0, out_b[0]}, 32'h1);
    chk({31'h0, out_b[4]}, 32'h0);
    wr(4'h4, 32'h00000000);
    go(0, -300);
  endtask : t_dead

  // Slow travel: the longest filter time is the safe pick here
  task automatic t_filt;
    wr(4'h5, 32'h10);
    go(0, 150);
    chk({31'h0, out_b[0]}, 32'h0);
    chk({31'h0, out_b[4]}, 32'h1);
    repeat (170) @(posedge mclk);
    chk({24'h0, out_b}, 32'h91);
    ce_in <= 1'b0;
    go(0, 300);
    chk({24'h0, out_b}, 32'h91);
    ce_in <= 1'b1;
    repeat (6) @(posedge mclk);
    chk({24'h0, out_b}, 32'h01);
  endtask : t_filt

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_regs();
    t_start_end();
    t_centre();
    t_hyst();
    t_clear();
    t_dead();
    t_filt();
    summarize();
  end
endmodule : pcs_cam_switch_tb
